// file: design/vsio_sync_outputs.sv
`include "vsio_defines.svh"

// Notes on behaviour
// R1 - Active flag high during active line portion
// R2 - Active flag toggles through vertical blanking
// R3 - Active flag can be high-impedance
// R4 - Active pin sampled as input in reset
// R5 - Strap high: outputs driven after reset
// R6 - Strap low: outputs stay high-impedance
// R7 - Field flag: one odd, zero even
// R8 - Field flag: one when vertical locked
// R9 - Field, line, lock straps set host mode
// R10 - Line flag: one noninverted, zero inverted
// R11 - Line flag: one when horizontal locked
// R12 - Board pulls line pin for strap
// R13 - Straps captured only during reset
// R14 - Strap loads enable bits four, three
// R15 - Internal setting picks indicator functions
// R16 - Outputs registered on pixel clock
module vsio_sync_outputs #(
  parameter int PIX_W = `VSIO_PIX_W
) (
  input  wire logic             clock_in,          // Pixel clock, 100 MHz
  input  wire logic             rst_n_in,          // Sync reset, active low
  input  wire logic             h_active_in,       // Horizontal active time, pixel path
  input  wire logic             odd_field_in,      // Odd field marker
  input  wire logic             vlock_in,          // Vertical loop locked
  input  wire logic             line_noninv_in,    // PAL line not inverted
  input  wire logic             hlock_in,          // Horizontal loop locked
  input  wire logic             hsync_in,          // Horizontal sync from timing
  input  wire logic             vsync_in,          // Vertical sync from timing
  input  wire logic [PIX_W-1:0] luma_in,           // Luma sample
  input  wire logic [PIX_W-1:0] chroma_in,         // Chroma sample
  input  wire logic             field_lock_sel_in, // 1: field pin shows vertical lock
  input  wire logic             line_lock_sel_in,  // 1: line pin shows horizontal lock
  input  wire logic             active_video_flag_pin_in,       // Active-video pin level
  input  wire logic             fid_pin_in,        // Field pin level
  input  wire logic             pal_line_flag_pin_in,       // PAL-line pin level
  input  wire logic             genlock_out_pin_in,       // Lock-output pin level
  output logic                  active_video_flag_out, // Active-video pin data
  output logic                  active_video_oe_out,   // Active-video pin enable
  output logic                  field_id_flag_out,     // Field pin data
  output logic                  field_id_oe_out,       // Field pin enable
  output logic                  pal_line_flag_out,     // PAL-line pin data
  output logic                  pal_line_oe_out,       // PAL-line pin enable
  output logic                  hsync_out,             // Horizontal sync data
  output logic                  vsync_out,             // Vertical sync data
  output logic                  sync_oe_out,           // Sync pins enable
  output logic [PIX_W-1:0]      luma_out,              // Luma bus data
  output logic [PIX_W-1:0]      chroma_bus_out,        // Chroma bus data
  output logic                  pixel_oe_out,          // Luma and chroma enable
  output logic [`VSIO_HMODE_W-1:0] host_mode_out      // Strapped host mode
);

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  // Each strap pin is asynchronous to the pixel clock, so it crosses two
  // flops before the capture logic looks at it
  localparam int N_STRAP_PINS = 4;

  wire logic [N_STRAP_PINS-1:0] pin_raw;
  wire logic [N_STRAP_PINS-1:0] pin_sync;

  assign pin_raw = {genlock_out_pin_in, pal_line_flag_pin_in, fid_pin_in, active_video_flag_pin_in};

  for (genvar p = 0; p < N_STRAP_PINS; p++) begin : g_pin_sync
    logic stage_a;
    logic stage_b;

    always_ff @(posedge clock_in) begin
      stage_a <= pin_raw[p];
      stage_b <= stage_a;
    end

    assign pin_sync[p] = stage_b;
  end

  // ------------------------------------------------------------------
  // Strap capture
  // ------------------------------------------------------------------
  vsio_strap_if strap_bus ();

  vsio_strap_capture u_strap (
    .clock_in    (clock_in),
    .rst_n_in    (rst_n_in),
    .active_video_flag_pin_in (pin_sync[0]),
    .fid_pin_in  (pin_sync[1]),
    .pal_line_flag_pin_in (pin_sync[2]),
    .genlock_out_pin_in (pin_sync[3]),
    .strap       (strap_bus.capture)
  );

  // ------------------------------------------------------------------
  // Indicator selection
  // ------------------------------------------------------------------
  vsio_pkg::vsio_field_mode_type field_mode;
  vsio_pkg::vsio_line_mode_type  line_mode;
  wire logic next_field_flag;
  wire logic next_line_flag;
  wire logic drive_pix;
  wire logic drive_sync;

  assign field_mode = field_lock_sel_in ? vsio_pkg::VSIO_FIELD_VLOCK
                                        : vsio_pkg::VSIO_FIELD_ODD_EVEN;  // R15
  assign line_mode  = line_lock_sel_in ? vsio_pkg::VSIO_LINE_HLOCK
                                       : vsio_pkg::VSIO_LINE_PHASE;      // R15
  assign next_field_flag = (field_mode == vsio_pkg::VSIO_FIELD_VLOCK) ? vlock_in
                                                                       : odd_field_in; // R7 R8
  assign next_line_flag  = (line_mode == vsio_pkg::VSIO_LINE_HLOCK) ? hlock_in
                                                                     : line_noninv_in; // R10 R11

  // ------------------------------------------------------------------
  // Enable decode
  // ------------------------------------------------------------------
  // Enables wait for strap_valid so the first edge after release still
  // leaves the pins floating while the captured straps settle
  assign drive_pix  = rst_n_in && strap_bus.strap_valid && strap_bus.ctrl[`VSIO_OE_PIX_BIT];
  assign drive_sync = rst_n_in && strap_bus.strap_valid && strap_bus.ctrl[`VSIO_OE_SYNC_BIT];

  // ------------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------------
  // Active flag follows the active time line by line, vertical
  // blanking included, so the far side can gate every line
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      active_video_flag_out <= 1'b0;
    end else begin
      active_video_flag_out <= h_active_in;  // R1 R2 R16
    end
  end

  // Field and line indicators carry whichever function is selected
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      field_id_flag_out <= 1'b0;
      pal_line_flag_out <= 1'b0;
    end else begin
      field_id_flag_out <= next_field_flag;  // R16
      pal_line_flag_out <= next_line_flag;   // R16
    end
  end

  // ------------------------------------------------------------------
  // Sync and sample registers
  // ------------------------------------------------------------------
  // Syncs share the pipeline stage of the samples they frame
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      hsync_out <= 1'b0;
      vsync_out <= 1'b0;
    end else begin
      hsync_out <= hsync_in;  // R16
      vsync_out <= vsync_in;  // R16
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      luma_out       <= '0;
      chroma_bus_out <= '0;
    end else begin
      luma_out       <= luma_in;    // R16
      chroma_bus_out <= chroma_in;  // R16
    end
  end

  // ------------------------------------------------------------------
  // Pin enables
  // ------------------------------------------------------------------
  // Enables stay low through reset so the strap pins float as inputs
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      active_video_oe_out <= 1'b0;  // R4
      field_id_oe_out     <= 1'b0;
      pal_line_oe_out     <= 1'b0;
      sync_oe_out         <= 1'b0;
    end else begin
      active_video_oe_out <= drive_sync;  // R3 R5 R6
      field_id_oe_out     <= drive_sync;  // R5 R6
      pal_line_oe_out     <= drive_sync;  // R5 R6 R12
      sync_oe_out         <= drive_sync;  // R5 R6
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pixel_oe_out <= 1'b0;  // R4
    end else begin
      pixel_oe_out <= drive_pix;  // R5 R6
    end
  end

  // ------------------------------------------------------------------
  // Host mode
  // ------------------------------------------------------------------
  // The strapped mode is frozen at release and held for the host port
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      host_mode_out <= `VSIO_HMODE_RESET;
    end else begin
      host_mode_out <= strap_bus.host_mode;  // R9
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  active_follow_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)  // R1
    $past(rst_n_in) |-> active_video_flag_out == $past(h_active_in))
    else $error("active flag not following active time");

  field_sel_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)  // R8
    $past(rst_n_in) && $past(field_lock_sel_in) |-> field_id_flag_out == $past(vlock_in))
    else $error("field flag not showing vertical lock");

  field_odd_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)  // R7
    $past(rst_n_in) && !$past(field_lock_sel_in) |-> field_id_flag_out == $past(odd_field_in))
    else $error("field flag not showing odd field");

  line_sel_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)  // R11
    $past(rst_n_in) && $past(line_lock_sel_in) |-> pal_line_flag_out == $past(hlock_in))
    else $error("line flag not showing horizontal lock");

  line_phase_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)  // R10
    $past(rst_n_in) && !$past(line_lock_sel_in) |-> pal_line_flag_out == $past(line_noninv_in))
    else $error("line flag not showing line phase");

  reset_float_a: assert property (@(posedge clock_in)  // R4
    !rst_n_in |=> !active_video_oe_out && !field_id_oe_out && !pal_line_oe_out &&
      !pixel_oe_out && !sync_oe_out)
    else $error("pins driven during reset");

  oe_strap_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)  // R5
    $past(rst_n_in, 2) && $past(rst_n_in) |->
      active_video_oe_out == strap_bus.ctrl[`VSIO_OE_SYNC_BIT] &&
      pixel_oe_out == strap_bus.ctrl[`VSIO_OE_PIX_BIT])
    else $error("enable does not match strap");

  oe_same_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)  // R6
    sync_oe_out == active_video_oe_out && field_id_oe_out == pal_line_oe_out &&
    field_id_oe_out == sync_oe_out)
    else $error("indicator enables disagree");

  // ------------------------------------------------------------------
  // Checks on the flag, sync and sample paths
  // ------------------------------------------------------------------
  // Gating on the past reset skips the first edge after release, where
  // the outputs still hold their reset values
  blank_toggle_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)  // R2
    $past(rst_n_in) && $past(vsync_in) |-> active_video_flag_out == $past(h_active_in))
    else $error("active flag held during vertical blanking");

  flag_idle_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)  // R1
    $past(rst_n_in) && !$past(h_active_in) |-> !active_video_flag_out)
    else $error("active flag high outside active time");

  sync_follow_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)  // R16
    $past(rst_n_in) |-> hsync_out == $past(hsync_in) && vsync_out == $past(vsync_in))
    else $error("sync outputs out of step");

  pixel_follow_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)  // R16
    $past(rst_n_in) |-> luma_out == $past(luma_in) && chroma_bus_out == $past(chroma_in))
    else $error("sample outputs out of step");

  flag_reset_a: assert property (@(posedge clock_in)  // R16
    !rst_n_in |=> !active_video_flag_out && !field_id_flag_out && !pal_line_flag_out &&
      !hsync_out && !vsync_out)
    else $error("indicators not cleared in reset");

  // ------------------------------------------------------------------
  // Checks on enables and straps
  // ------------------------------------------------------------------
  release_float_a: assert property (@(posedge clock_in)  // R13
    rst_n_in && !$past(rst_n_in) |=> !sync_oe_out && !pixel_oe_out)
    else $error("pins driven on first edge after reset");

  sync_float_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)  // R6
    $past(rst_n_in, 2) && $past(rst_n_in) && !strap_bus.ctrl[`VSIO_OE_SYNC_BIT] |->
      !sync_oe_out && !active_video_oe_out && !field_id_oe_out && !pal_line_oe_out)
    else $error("sync pins driven with strap low");

  pix_float_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)  // R6
    $past(rst_n_in, 2) && $past(rst_n_in) && !strap_bus.ctrl[`VSIO_OE_PIX_BIT] |-> !pixel_oe_out)
    else $error("sample bus driven with strap low");

  sync_drive_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)  // R5
    $past(rst_n_in, 2) && $past(rst_n_in) && strap_bus.ctrl[`VSIO_OE_SYNC_BIT] |->
      sync_oe_out && field_id_oe_out && pal_line_oe_out)
    else $error("sync pins floating with strap high");

  pix_drive_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)  // R5
    $past(rst_n_in, 2) && $past(rst_n_in) && strap_bus.ctrl[`VSIO_OE_PIX_BIT] |-> pixel_oe_out)
    else $error("sample bus floating with strap high");

  host_strap_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)  // R9
    $past(rst_n_in) |-> host_mode_out == $past(strap_bus.host_mode))
    else $error("host mode not taken from straps");

  host_hold_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)  // R13
    $past(rst_n_in, 2) && $past(rst_n_in) |-> $stable(host_mode_out))
    else $error("host mode changed after reset");

endmodule : vsio_sync_outputs

// file: design/vsio_defines.svh
`ifndef VSIO_DEFINES_SVH
`define VSIO_DEFINES_SVH

`define VSIO_PIX_W        10
`define VSIO_OE_PIX_BIT   4
`define VSIO_OE_SYNC_BIT  3
`define VSIO_CTRL_W       5
`define VSIO_HMODE_W      3
`define VSIO_CTRL_RESET   5'h00
`define VSIO_HMODE_RESET  3'h0

`endif

// file: design/vsio_pkg.sv
package vsio_pkg;

  typedef enum logic {
    VSIO_FIELD_ODD_EVEN,
    VSIO_FIELD_VLOCK
  } vsio_field_mode_type;

  typedef enum logic {
    VSIO_LINE_PHASE,
    VSIO_LINE_HLOCK
  } vsio_line_mode_type;

endpackage : vsio_pkg

// file: design/vsio_strap_if.sv
`include "vsio_defines.svh"

interface vsio_strap_if;
  logic                       strap_valid;
  logic [`VSIO_CTRL_W-1:0]    ctrl;
  logic [`VSIO_HMODE_W-1:0]   host_mode;

  modport capture (output strap_valid, output ctrl, output host_mode);
  modport use_side (input strap_valid, input ctrl, input host_mode);
endinterface : vsio_strap_if

// file: design/vsio_strap_capture.sv
`include "vsio_defines.svh"

module vsio_strap_capture (
  input  wire logic        clock_in,     // Pixel clock
  input  wire logic        rst_n_in,     // Sync reset, active low
  input  wire logic        active_video_flag_pin_in,  // Synchronised active-video pin level
  input  wire logic        fid_pin_in,   // Synchronised field pin level
  input  wire logic        pal_line_flag_pin_in,  // Synchronised PAL-line pin level
  input  wire logic        genlock_out_pin_in,  // Synchronised lock-output pin level
  vsio_strap_if.capture    strap         // Captured straps
);

  // ------------------------------------------------------------------
  // Capture while reset is held, freeze after release
  // ------------------------------------------------------------------
  logic [`VSIO_CTRL_W-1:0]  next_ctrl;
  logic [`VSIO_HMODE_W-1:0] next_host_mode;

  always_comb begin
    next_ctrl = `VSIO_CTRL_RESET;
    next_ctrl[`VSIO_OE_PIX_BIT]  = active_video_flag_pin_in;  // R14
    next_ctrl[`VSIO_OE_SYNC_BIT] = active_video_flag_pin_in;  // R14
  end

  assign next_host_mode = {genlock_out_pin_in, pal_line_flag_pin_in, fid_pin_in};  // R9

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      strap.ctrl        <= next_ctrl;       // R4
      strap.host_mode   <= next_host_mode;  // R13
      strap.strap_valid <= 1'b0;
    end else begin
      strap.strap_valid <= 1'b1;
    end
  end

  strap_hold_a: assert property (@(posedge clock_in)  // R13
    rst_n_in && $past(rst_n_in) |-> $stable(strap.host_mode) && $stable(strap.ctrl))
    else $error("strap changed after reset");

endmodule : vsio_strap_capture

// file: testbench/vsio_capture_model.sv
module vsio_capture_model (
  input  wire logic active_video_flag_strap_in,          // Board pull on active-video pin
  input  wire logic fid_strap_in,           // Board pull on field pin
  input  wire logic pal_line_flag_strap_in,          // Board pull on PAL-line pin
  input  wire logic genlock_out_strap_in,          // Board pull on lock-output pin
  input  wire logic active_video_flag_in,   // Device active-video data
  input  wire logic active_video_oe_in,     // Device active-video enable
  input  wire logic field_id_flag_in,       // Device field data
  input  wire logic field_id_oe_in,         // Device field enable
  input  wire logic pal_line_flag_in,       // Device PAL-line data
  input  wire logic pal_line_oe_in,         // Device PAL-line enable
  output logic      active_video_flag_pin_out,           // Resolved active-video pin
  output logic      fid_pin_out,            // Resolved field pin
  output logic      pal_line_flag_pin_out,           // Resolved PAL-line pin
  output logic      genlock_out_pin_out            // Resolved lock-output pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // Released pins fall back to the board pull level
  assign active_video_flag_pin_out = active_video_oe_in ? active_video_flag_in : active_video_flag_strap_in;
  assign fid_pin_out  = field_id_oe_in ? field_id_flag_in : fid_strap_in;
  assign pal_line_flag_pin_out = pal_line_oe_in ? pal_line_flag_in : pal_line_flag_strap_in;
  assign genlock_out_pin_out = genlock_out_strap_in;
endmodule : vsio_capture_model

// file: testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic       h_act = 1'b0, odd_f = 1'b0, vlk = 1'b0, l_ni = 1'b0, hlk = 1'b0;
  logic       hs = 1'b0, vs = 1'b0, f_sel = 1'b0, l_sel = 1'b0;
  logic [9:0] luma = 10'h000, chroma = 10'h000;
  logic [3:0] strap = 4'hB; // lock, line, field, active
  logic       av_d, av_oe, fi_d, fi_oe, pl_d, pl_oe, hs_o, vs_o, s_oe, px_oe;
  logic [9:0] luma_o, chroma_o;
  logic [2:0] hmode;
  wire        av_pin, fi_pin, pl_pin, gl_pin;
  int         n_mismatch = 0;
  int         samples_checked = 0;

  always #5 clock_in = ~clock_in;

  vsio_sync_outputs DUT (.clock_in(clock_in), .rst_n_in(rst_n_in), .h_active_in(h_act), .odd_field_in(odd_f),
    .vlock_in(vlk), .line_noninv_in(l_ni), .hlock_in(hlk), .hsync_in(hs), .vsync_in(vs), .luma_in(luma),
    .chroma_in(chroma), .field_lock_sel_in(f_sel), .line_lock_sel_in(l_sel), .active_video_flag_pin_in(av_pin),
    .fid_pin_in(fi_pin), .pal_line_flag_pin_in(pl_pin), .genlock_out_pin_in(gl_pin), .active_video_flag_out(av_d),
    .active_video_oe_out(av_oe), .field_id_flag_out(fi_d), .field_id_oe_out(fi_oe), .pal_line_flag_out(pl_d),
    .pal_line_oe_out(pl_oe), .hsync_out(hs_o), .vsync_out(vs_o), .sync_oe_out(s_oe), .luma_out(luma_o),
    .chroma_bus_out(chroma_o), .pixel_oe_out(px_oe), .host_mode_out(hmode));

  vsio_capture_model partner (.active_video_flag_strap_in(strap[0]), .fid_strap_in(strap[1]), .pal_line_flag_strap_in(strap[2]),
    .genlock_out_strap_in(strap[3]), .active_video_flag_in(av_d), .active_video_oe_in(av_oe),
    .field_id_flag_in(fi_d), .field_id_oe_in(fi_oe), .pal_line_flag_in(pl_d), .pal_line_oe_in(pl_oe),
    .active_video_flag_pin_out(av_pin), .fid_pin_out(fi_pin), .pal_line_flag_pin_out(pl_pin), .genlock_out_pin_out(gl_pin));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // ---------------------------------------------------------------
  // Strap capture through reset, then straps ignored
  // ---------------------------------------------------------------
  task automatic test_strap(input logic [3:0] s, input int n);
    @(posedge clock_in);
    strap    <= s;
    rst_n_in <= 1'b0;
    repeat (n) @(posedge clock_in);
    #1 chk({px_oe, s_oe, av_oe, fi_oe, pl_oe}, 5'h00);
    @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    @(posedge clock_in);
    #1 chk(hmode, s[3:1]);
    chk({px_oe, s_oe, av_oe, fi_oe, pl_oe}, {5{s[0]}});
    @(posedge clock_in);
    strap <= ~s;
    repeat (3) @(posedge clock_in);
    #1 chk({hmode, px_oe, s_oe}, {s[3:1], s[0], s[0]});
  endtask : test_strap

  // ---------------------------------------------------------------
  // Flag, sync and sample path, one cycle each
  // ---------------------------------------------------------------
  task automatic test_data(input logic drive);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock_in);
      {vs, hs, h_act} <= i[2:0];
      luma            <= 10'h2A5 ^ 10'(i);
      chroma          <= 10'h15A + 10'(i);
      @(posedge clock_in);
      #1 chk({av_d, hs_o, vs_o}, {i[0], i[1], i[2]});
      chk({luma_o, chroma_o}, {10'h2A5 ^ 10'(i), 10'h15A + 10'(i)});
      chk(av_pin, drive ? i[0] : strap[0]);
    end
  endtask : test_data

  // ---------------------------------------------------------------
  // Field and line pin functions under both selections
  // ---------------------------------------------------------------
  task automatic test_modes();
    for (int i = 0; i < 16; i++) begin
      @(posedge clock_in);
      {l_sel, f_sel} <= i[1:0];
      {odd_f, hlk}   <= {i[2], i[2]};
      {vlk, l_ni}    <= {i[3], i[3]};
      @(posedge clock_in);
      #1 chk(fi_d, i[0] ? i[3] : i[2]);
      chk(pl_d, i[1] ? i[2] : i[3]);
      chk({fi_pin, pl_pin}, {fi_d, pl_d});
    end
  endtask : test_modes

  initial begin
    test_strap(4'hB, 1);
    test_data(1'b1);
    test_modes();
    test_strap(4'h6, 5);
    test_data(1'b0);
    tally_and_finish();
  end

  initial begin
    #100us;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : testbench
